/* design/pxc_regs.sv */
// Chosen here: the address-and-strobe port.
`default_nettype none
// Notes on behaviour
// [R1] Station address read-only, captured from straps at reset, writes ignored.
// [R2] Detection status: 00 searching, 01 needs power, 10 no power, 11 reserved.
// [R3] Software ignores detection status unless detection enable is set.
// [R4] Eight-bit CRC error counter saturates at FF, cleared by read, restarts.
// [R5] Locations after control-4 (three) are reserved, no function.
// [R6] Sticky crossover-disable bit for forced 10/100; default one.
// [R7] Half duplex: selector 00/01 carrier = rx_dv|tx_en, 10/11 rx_dv.
// [R8] Full duplex: selector 00/10 carrier = rx_dv, 01/11 zero.
// [R9] Read-only flag set when configuration EEPROM is detected.
// [R10] Sticky backplane reduced-power enable, default zero.
// [R11] Sticky 100M amplitude selector, default 110, 011 reserved.
// [R12] Sticky 1000M amplitude selector, default 000, 011 reserved.
// [R13] Sticky 1000M edge-rate selector, default 111.
// [R14] Sticky TX and RX skew selectors, defaults from straps.
// [R15] Sticky max packet length selector, default 00.
// [R16] Sticky 10M no-preamble bit: one accepts frames without preamble.
// [R17] Sticky fields survive software reset, return to default on hardware reset.
// [R18] Reserved bits and locations read zero and ignore writes.
module pxc_regs
   import pxc_pkg::*;
#(
   parameter int ADDR_W = 5,
   parameter int DATA_W = 16
) (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic              soft_rst,
   input  wire logic [4:0]        config_strap_pins,
   input  wire logic [1:0]        strap_tx_skew,
   input  wire logic [1:0]        strap_rx_skew,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              crc_err_pulse,
   input  wire logic [1:0]        pd_status_in,
   input  wire logic              eeprom_detected,
   input  wire logic              full_duplex,
   input  wire logic              rx_dv,
   input  wire logic              tx_en,
   output logic                   carrier_sense,
   output logic                   rx_preamble_required,
   output pxc_cfg_type            cfg,
   output logic                   irq
);

   // ------------------------------------------------------------
   // Input synchronisers (straps and pin-derived levels)
   // ------------------------------------------------------------
   logic [4:0] strap_s1_r, strap_s2_r;
   logic [3:0] skew_s1_r, skew_s2_r;
   logic [1:0] pd_s1_r, pd_s2_r;
   logic       eep_s1_r, eep_s2_r;
   logic       srst_s1_r, srst_s2_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_s1_r <= 5'h00;
         strap_s2_r <= 5'h00;
         skew_s1_r  <= 4'h0;
         skew_s2_r  <= 4'h0;
         pd_s1_r    <= 2'h0;
         pd_s2_r    <= 2'h0;
         eep_s1_r   <= 1'h0;
         eep_s2_r   <= 1'h0;
         srst_s1_r  <= 1'h0;
         srst_s2_r  <= 1'h0;
      end else begin
         strap_s1_r <= config_strap_pins;
         strap_s2_r <= strap_s1_r;
         skew_s1_r  <= {strap_tx_skew, strap_rx_skew};
         skew_s2_r  <= skew_s1_r;
         pd_s1_r    <= pd_status_in;
         pd_s2_r    <= pd_s1_r;
         eep_s1_r   <= eeprom_detected;
         eep_s2_r   <= eep_s1_r;
         srst_s1_r  <= soft_rst;
         srst_s2_r  <= srst_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   pxc_state_type          state_r, state_nxt;
   logic                   caught_r, caught_nxt;
   logic [1:0]             settle_r, settle_nxt;
   logic [4:0]             sta_addr_r, sta_addr_nxt;
   pxc_cfg_type            cfg_r, cfg_nxt;
   logic [1:0]             crs_sel_r, crs_sel_nxt;
   logic [7:0]             crc_cnt_r, crc_cnt_nxt;
   logic [PXC_IRQ_W-1:0]   irq_stat_r, irq_stat_nxt;
   logic [PXC_IRQ_W-1:0]   irq_mask_r, irq_mask_nxt;
   logic [1:0]             pd_prev_r, pd_prev_nxt;
   logic                   eep_prev_r, eep_prev_nxt;
   logic [DATA_W-1:0]      rdata_r, rdata_nxt;
   logic                   crs_r, crs_nxt;

   logic                   wr_c4, wr_c5, wr_sk, wr_ist, wr_imk, rd_c4;
   logic [DATA_W-1:0]      rd_mux;
   logic [PXC_IRQ_W-1:0]   irq_ev;

   assign wr_c4  = reg_wr && (reg_addr == PXC_ADDR_CTRL4);
   assign wr_c5  = reg_wr && (reg_addr == PXC_ADDR_CTRL5);
   assign wr_sk  = reg_wr && (reg_addr == PXC_ADDR_SKEW);
   assign wr_ist = reg_wr && (reg_addr == PXC_ADDR_IRQ_STAT);
   assign wr_imk = reg_wr && (reg_addr == PXC_ADDR_IRQ_MASK);
   assign rd_c4  = reg_rd && (reg_addr == PXC_ADDR_CTRL4);

   // ------------------------------------------------------------
   // Read multiplexer
   // ------------------------------------------------------------
   always_comb begin
      rd_mux = '0;
      case (reg_addr)
         PXC_ADDR_CTRL4: begin
            rd_mux[PXC_C4_ADDR_LSB +: 5] = sta_addr_r;            // see [R1]
            rd_mux[PXC_C4_PDEN_BIT]      = cfg_r.pd_detect_en;
            rd_mux[PXC_C4_PDST_LSB +: 2] = pd_s2_r;               // see [R2]
            rd_mux[PXC_C4_CRC_LSB +: 8]  = crc_cnt_r;
         end
         PXC_ADDR_CTRL5: begin
            rd_mux[PXC_C5_MDIX_BIT]      = cfg_r.mdix_forced_dis;
            rd_mux[PXC_C5_CRS_LSB +: 2]  = crs_sel_r;
            rd_mux[PXC_C5_EEP_BIT]       = eep_s2_r;              // see [R9]
            rd_mux[PXC_C5_FELB_BIT]      = cfg_r.far_end_loop;
            rd_mux[PXC_C5_BPRP_BIT]      = cfg_r.backplane_low_pwr;
            rd_mux[PXC_C5_A100_LSB +: 3] = cfg_r.amp_100;
            rd_mux[PXC_C5_A1G_LSB +: 3]  = cfg_r.amp_1000;
            rd_mux[PXC_C5_EDGE_LSB +: 3] = cfg_r.edge_1000;
         end
         PXC_ADDR_SKEW: begin
            rd_mux[PXC_SK_TX_LSB +: 2]    = cfg_r.tx_skew;
            rd_mux[PXC_SK_RX_LSB +: 2]    = cfg_r.rx_skew;
            rd_mux[PXC_SK_JUMBO_LSB +: 2] = cfg_r.jumbo_sel;
            rd_mux[PXC_SK_NOPRE_BIT]      = cfg_r.no_preamble;
         end
         PXC_ADDR_IRQ_STAT: rd_mux[PXC_IRQ_W-1:0] = irq_stat_r;
         PXC_ADDR_IRQ_MASK: rd_mux[PXC_IRQ_W-1:0] = irq_mask_r;
         default:           rd_mux = '0;                          // see [R5] [R18]
      endcase
   end

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      state_nxt    = state_r;
      caught_nxt   = caught_r;
      settle_nxt   = {settle_r[0], 1'b1};
      sta_addr_nxt = sta_addr_r;
      cfg_nxt      = cfg_r;
      crs_sel_nxt  = crs_sel_r;
      crc_cnt_nxt  = crc_cnt_r;
      irq_mask_nxt = irq_mask_r;
      pd_prev_nxt  = pd_s2_r;
      eep_prev_nxt = eep_s2_r;
      rdata_nxt    = reg_rd ? rd_mux : '0;
      irq_ev       = '0;

      // Straps are caught once, after synchronisers have settled
      // Capturing before the chain fills would latch the reset zeros
      case (state_r)
         PXC_ST_RUN: begin
            if (!caught_r && settle_r[1]) begin
               caught_nxt   = 1'b1;
               sta_addr_nxt = strap_s2_r;                         // see [R1]
               cfg_nxt.tx_skew = skew_s2_r[3:2];                  // see [R14]
               cfg_nxt.rx_skew = skew_s2_r[1:0];
            end
            if (srst_s2_r) begin
               state_nxt = PXC_ST_SWRST;
            end
         end
         PXC_ST_SWRST: begin
            // Only non-sticky state resets here
            cfg_nxt.far_end_loop = 1'b0;                          // see [R17]
            crc_cnt_nxt          = '0;
            if (!srst_s2_r) begin
               state_nxt = PXC_ST_RUN;
            end
         end
         default: state_nxt = PXC_ST_RUN;
      endcase

      if (wr_c4) begin
         cfg_nxt.pd_detect_en = reg_wdata[PXC_C4_PDEN_BIT];
      end
      if (wr_c5) begin
         cfg_nxt.mdix_forced_dis   = reg_wdata[PXC_C5_MDIX_BIT];  // see [R6]
         crs_sel_nxt               = reg_wdata[PXC_C5_CRS_LSB +: 2];
         cfg_nxt.far_end_loop      = reg_wdata[PXC_C5_FELB_BIT];
         cfg_nxt.backplane_low_pwr = reg_wdata[PXC_C5_BPRP_BIT];  // see [R10]
         cfg_nxt.amp_100           = reg_wdata[PXC_C5_A100_LSB +: 3]; // see [R11]
         cfg_nxt.amp_1000          = reg_wdata[PXC_C5_A1G_LSB +: 3];  // see [R12]
         cfg_nxt.edge_1000         = reg_wdata[PXC_C5_EDGE_LSB +: 3]; // see [R13]
      end
      if (wr_sk) begin
         cfg_nxt.tx_skew     = reg_wdata[PXC_SK_TX_LSB +: 2];     // see [R14]
         cfg_nxt.rx_skew     = reg_wdata[PXC_SK_RX_LSB +: 2];
         cfg_nxt.jumbo_sel   = reg_wdata[PXC_SK_JUMBO_LSB +: 2];  // see [R15]
         cfg_nxt.no_preamble = reg_wdata[PXC_SK_NOPRE_BIT];       // see [R16]
      end
      if (wr_imk) begin
         irq_mask_nxt = reg_wdata[PXC_IRQ_W-1:0];
      end

      // Read clears first; an error in the same cycle counts from zero
      if (rd_c4) begin
         crc_cnt_nxt = '0;                                        // see [R4]
      end
      if (crc_err_pulse && (crc_cnt_nxt != PXC_CRC_MAX)) begin
         crc_cnt_nxt = crc_cnt_nxt + 8'h01;                       // see [R4]
         irq_ev[PXC_IRQ_CRC_SAT] = (crc_cnt_nxt == PXC_CRC_MAX);
      end

      // Found events only count while detection is enabled
      irq_ev[PXC_IRQ_PD_FOUND] = cfg_r.pd_detect_en && (pd_s2_r != pd_prev_r) &&
                                 ((pd_s2_r == PXC_PD_POWER) || (pd_s2_r == PXC_PD_NOPOWER)); // see [R3]
      irq_ev[PXC_IRQ_EEPROM]   = eep_s2_r && !eep_prev_r;

      // Set wins over write-one-to-clear
      irq_stat_nxt = irq_stat_r;
      if (wr_ist) begin
         irq_stat_nxt = irq_stat_nxt & ~reg_wdata[PXC_IRQ_W-1:0];
      end
      irq_stat_nxt = irq_stat_nxt | irq_ev;

      // Carrier sense selection
      if (!full_duplex) begin
         crs_nxt = crs_sel_r[1] ? rx_dv : (rx_dv | tx_en);        // see [R7]
      end else begin
         crs_nxt = crs_sel_r[0] ? 1'b0 : rx_dv;                   // see [R8]
      end
   end

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r    <= PXC_ST_RUN;
         caught_r   <= 1'b0;
         settle_r   <= 2'h0;
         sta_addr_r <= 5'h00;
         cfg_r      <= '{mdix_forced_dis:   PXC_RST_MDIX_DIS,
                         far_end_loop:      1'b0,
                         backplane_low_pwr: 1'b0,
                         amp_100:           PXC_RST_AMP100,
                         amp_1000:          PXC_RST_AMP1G,
                         edge_1000:         PXC_RST_EDGE,
                         tx_skew:           2'h0,
                         rx_skew:           2'h0,
                         jumbo_sel:         PXC_RST_JUMBO,
                         no_preamble:       1'b0,
                         pd_detect_en:      1'b0};                // see [R17]
         crs_sel_r  <= PXC_RST_CRS_SEL;
         crc_cnt_r  <= 8'h00;
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         pd_prev_r  <= 2'h0;
         eep_prev_r <= 1'b0;
         rdata_r    <= '0;
         crs_r      <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         caught_r   <= caught_nxt;
         settle_r   <= settle_nxt;
         sta_addr_r <= sta_addr_nxt;
         cfg_r      <= cfg_nxt;
         crs_sel_r  <= crs_sel_nxt;
         crc_cnt_r  <= crc_cnt_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         pd_prev_r  <= pd_prev_nxt;
         eep_prev_r <= eep_prev_nxt;
         rdata_r    <= rdata_nxt;
         crs_r      <= crs_nxt;
      end
   end

   assign reg_rdata            = rdata_r;
   assign cfg                  = cfg_r;
   assign carrier_sense        = crs_r;
   assign rx_preamble_required = !cfg_r.no_preamble;              // see [R16]
   assign irq                  = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

/* pkg/pxc_pkg.sv */
`default_nettype none
package pxc_pkg;

   // ------------------------------------------------------------
   // Register map (extended page locations)
   // ------------------------------------------------------------
   localparam logic [4:0]  PXC_ADDR_CTRL4    = 5'h17;
   localparam logic [4:0]  PXC_ADDR_RSVD_LO  = 5'h18;
   localparam logic [4:0]  PXC_ADDR_RSVD_HI  = 5'h1A;
   localparam logic [4:0]  PXC_ADDR_CTRL5    = 5'h1B;
   localparam logic [4:0]  PXC_ADDR_SKEW     = 5'h1C;
   localparam logic [4:0]  PXC_ADDR_IRQ_STAT = 5'h1F;
   localparam logic [4:0]  PXC_ADDR_IRQ_MASK = 5'h10;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int PXC_C4_ADDR_LSB   = 11;
   localparam int PXC_C4_PDEN_BIT   = 10;
   localparam int PXC_C4_PDST_LSB   = 8;
   localparam int PXC_C4_CRC_LSB    = 0;
   localparam int PXC_C5_MDIX_BIT   = 15;
   localparam int PXC_C5_CRS_LSB    = 12;
   localparam int PXC_C5_EEP_BIT    = 11;
   localparam int PXC_C5_FELB_BIT   = 10;
   localparam int PXC_C5_BPRP_BIT   = 9;
   localparam int PXC_C5_A100_LSB   = 6;
   localparam int PXC_C5_A1G_LSB    = 3;
   localparam int PXC_C5_EDGE_LSB   = 0;
   localparam int PXC_SK_TX_LSB     = 14;
   localparam int PXC_SK_RX_LSB     = 12;
   localparam int PXC_SK_JUMBO_LSB  = 10;
   localparam int PXC_SK_NOPRE_BIT  = 9;

   // ------------------------------------------------------------
   // Reset values, counter limit and reserved amplitude code
   // ------------------------------------------------------------
   localparam logic       PXC_RST_MDIX_DIS = 1'h1;
   localparam logic [1:0] PXC_RST_CRS_SEL  = 2'h0;
   localparam logic [2:0] PXC_RST_AMP100   = 3'h6;
   localparam logic [2:0] PXC_RST_AMP1G    = 3'h0;
   localparam logic [2:0] PXC_RST_EDGE     = 3'h7;
   localparam logic [1:0] PXC_RST_JUMBO    = 2'h0;
   localparam logic [7:0] PXC_CRC_MAX      = 8'hFF;
   localparam logic [2:0] PXC_AMP_RSVD     = 3'h3;

   // Interrupt status bit positions
   localparam int PXC_IRQ_CRC_SAT   = 0;
   localparam int PXC_IRQ_PD_FOUND  = 1;
   localparam int PXC_IRQ_EEPROM    = 2;
   localparam int PXC_IRQ_W         = 3;

   typedef enum logic [1:0] {
      PXC_PD_SEARCH  = 2'b00,
      PXC_PD_POWER   = 2'b01,
      PXC_PD_NOPOWER = 2'b10,
      PXC_PD_RSVD    = 2'b11
   } pxc_pd_type;

   typedef enum logic [1:0] {
      PXC_ST_RUN   = 2'b00,
      PXC_ST_SWRST = 2'b01
   } pxc_state_type;

   // Trim and mode settings handed to the analog and datapath logic
   typedef struct packed {
      logic       mdix_forced_dis;
      logic       far_end_loop;
      logic       backplane_low_pwr;
      logic [2:0] amp_100;
      logic [2:0] amp_1000;
      logic [2:0] edge_1000;
      logic [1:0] tx_skew;
      logic [1:0] rx_skew;
      logic [1:0] jumbo_sel;
      logic       no_preamble;
      logic       pd_detect_en;
   } pxc_cfg_type;

endpackage
`default_nettype wire

/* verification/pxc_mac_model.sv */
`default_nettype none
module pxc_mac_model (
   input  wire logic core_clk,
   input  wire logic run,
   output logic      rx_dv,
   output logic      tx_en
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;
   initial begin
      cnt = 2'h0;
   end
   // Walks all rx_dv/tx_en pairs while running, idles at zero
   always @(posedge core_clk) begin
      cnt <= run ? cnt + 2'h1 : 2'h0;
   end
   assign rx_dv = cnt[0];
   assign tx_en = cnt[1];
endmodule
`default_nettype wire

/* verification/pxc_regs_chk.sv */
`default_nettype none
module pxc_regs_chk
   import pxc_pkg::*;
#(
   parameter int ADDR_W = 5,
   parameter int DATA_W = 16
) (
   input wire logic              core_clk,
   input wire logic              rst_b,
   input wire logic              soft_rst,
   input wire logic [4:0]        config_strap_pins,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              crc_err_pulse,
   input wire logic              full_duplex,
   input wire logic              rx_dv,
   input wire logic              tx_en,
   input wire logic              carrier_sense,
   input wire logic              rx_preamble_required,
   input wire pxc_cfg_type       cfg
);
   // ----------------------------------------
   // Shadow of the carrier selector (sticky)
   // ----------------------------------------
   logic [1:0] sel_r;
   logic [1:0] sel_nxt;
   always_comb begin
      sel_nxt = sel_r;
      if (reg_wr && reg_addr == PXC_ADDR_CTRL5) begin
         sel_nxt = reg_wdata[13:12];
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_r <= PXC_RST_CRS_SEL;
      end else begin
         sel_r <= sel_nxt;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_rd4;
      reg_rd && reg_addr == PXC_ADDR_CTRL4 && !crc_err_pulse;
   endsequence
   a_crs_half_or: assert property (!full_duplex && !sel_r[1] |=> carrier_sense == $past(rx_dv | tx_en))
      else $error("half duplex carrier not rx_dv or tx_en");
   a_crs_half_rx: assert property (!full_duplex && sel_r[1] |=> carrier_sense == $past(rx_dv))
      else $error("half duplex carrier not rx_dv");
   a_crs_full: assert property (full_duplex |=> carrier_sense == ($past(rx_dv) && !$past(sel_r[0])))
      else $error("full duplex carrier wrong");
   a_rsvd_loc_zero: assert property (
      reg_rd && reg_addr inside {[PXC_ADDR_RSVD_LO:PXC_ADDR_RSVD_HI]} |=> reg_rdata == '0)
      else $error("reserved location not zero");
   a_rsvd_bits_zero: assert property (reg_rd && reg_addr == PXC_ADDR_SKEW |=> reg_rdata[8:0] == '0)
      else $error("reserved skew bits not zero");
   a_addr_strap: assert property (
      reg_rd && reg_addr == PXC_ADDR_CTRL4 |=> reg_rdata[15:11] == $past(config_strap_pins))
      else $error("station address not strap value");
   a_crc_clear: assert property (s_rd4 ##1 s_rd4 |=> reg_rdata[7:0] == '0)
      else $error("counter not cleared by read");
   a_ctrl5_write: assert property (
      reg_wr && reg_addr == PXC_ADDR_CTRL5 |=> cfg.amp_100 == $past(reg_wdata[8:6])
      && cfg.amp_1000 == $past(reg_wdata[5:3]) && cfg.edge_1000 == $past(reg_wdata[2:0])
      && cfg.mdix_forced_dis == $past(reg_wdata[15]) && cfg.backplane_low_pwr == $past(reg_wdata[9]))
      else $error("control five write not applied");
   a_skew_write: assert property (
      reg_wr && reg_addr == PXC_ADDR_SKEW |=> cfg.tx_skew == $past(reg_wdata[15:14])
      && cfg.rx_skew == $past(reg_wdata[13:12]) && cfg.jumbo_sel == $past(reg_wdata[11:10])
      && cfg.no_preamble == $past(reg_wdata[9]))
      else $error("skew write not applied");
   a_pre_inverse: assert property (rx_preamble_required == !cfg.no_preamble)
      else $error("preamble requirement not inverse");
   a_sticky_keep: assert property (
      soft_rst && !reg_wr |=> $stable({cfg.mdix_forced_dis, cfg.backplane_low_pwr, cfg.amp_100, cfg.amp_1000,
      cfg.edge_1000, cfg.jumbo_sel, cfg.no_preamble, cfg.pd_detect_en}))
      else $error("sticky field changed during soft reset");
endmodule
bind pxc_regs pxc_regs_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
   .soft_rst(soft_rst), .config_strap_pins(config_strap_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crc_err_pulse(crc_err_pulse),
   .full_duplex(full_duplex), .rx_dv(rx_dv), .tx_en(tx_en), .carrier_sense(carrier_sense),
   .rx_preamble_required(rx_preamble_required), .cfg(cfg));
`default_nettype wire

/* verification/tb_pxc_regs.sv */
`default_nettype none
module tb_pxc_regs
   import pxc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst_b, soft_rst, reg_wr, reg_rd, crc_err_pulse, eeprom_detected, full_duplex, run;
   logic rx_dv, tx_en, carrier_sense, rx_preamble_required, irq;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [1:0]  pd_status_in;
   pxc_cfg_type cfg;
   int errors, n_checks;

   pxc_regs u_dut (.core_clk(core_clk), .rst_b(rst_b), .soft_rst(soft_rst), .config_strap_pins(5'h15),
      .strap_tx_skew(2'h2), .strap_rx_skew(2'h1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crc_err_pulse(crc_err_pulse), .pd_status_in(pd_status_in),
      .eeprom_detected(eeprom_detected), .full_duplex(full_duplex), .rx_dv(rx_dv), .tx_en(tx_en),
      .carrier_sense(carrier_sense), .rx_preamble_required(rx_preamble_required), .cfg(cfg), .irq(irq));
   pxc_mac_model u_mac (.core_clk(core_clk), .run(run), .rx_dv(rx_dv), .tx_en(tx_en));

   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      chk_word({15'h0, got}, {15'h0, exp}, msg);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string msg);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      chk_word(reg_rdata, exp, msg);
   endtask
   task automatic hard_reset;
      @(posedge core_clk);
      rst_b <= 1'h0;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'h1;
      repeat (5) @(posedge core_clk);
   endtask
   task automatic pulse_crc(input int n);
      repeat (n) begin
         @(posedge core_clk);
         crc_err_pulse <= 1'h1;
      end
      @(posedge core_clk);
      crc_err_pulse <= 1'h0;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_defaults;
      rd(PXC_ADDR_CTRL5, 16'h8187, "ctrl5 default");
      rd(PXC_ADDR_SKEW, 16'h9000, "skew default");
      rd(PXC_ADDR_CTRL4, 16'hA800, "ctrl4 default");
      $display("done defaults");
   endtask
   task automatic t_sticky;
      wr(PXC_ADDR_CTRL5, 16'hFFFF);
      wr(PXC_ADDR_SKEW, 16'hFFFF);
      wr(PXC_ADDR_CTRL4, 16'hFFFF);
      rd(PXC_ADDR_CTRL5, 16'hB7FF, "ctrl5 written");
      rd(PXC_ADDR_CTRL4, 16'hAC00, "ctrl4 read-only kept");
      @(posedge core_clk);
      soft_rst <= 1'h1;
      repeat (5) @(posedge core_clk);
      soft_rst <= 1'h0;
      repeat (4) @(posedge core_clk);
      rd(PXC_ADDR_CTRL5, 16'hB3FF, "ctrl5 after soft reset");
      rd(PXC_ADDR_SKEW, 16'hFE00, "skew after soft reset");
      hard_reset();
      t_defaults();
      $display("done sticky");
   endtask
   task automatic t_detect;
      wr(PXC_ADDR_CTRL4, 16'h0400);
      @(posedge core_clk);
      pd_status_in <= PXC_PD_POWER;
      eeprom_detected <= 1'h1;
      repeat (6) @(posedge core_clk);
      // Status only read once detection is enabled
      rd(PXC_ADDR_CTRL4, 16'hAD00, "detect status");
      rd(PXC_ADDR_CTRL5, 16'h8987, "eeprom flag");
      chk_bit(irq, 1'h0, "masked irq");
      wr(PXC_ADDR_IRQ_MASK, 16'h0004);
      @(posedge core_clk);
      #1;
      chk_bit(irq, 1'h1, "unmasked irq");
      wr(PXC_ADDR_IRQ_STAT, 16'h0007);
      @(posedge core_clk);
      #1;
      chk_bit(irq, 1'h0, "irq cleared");
      $display("done detect");
   endtask
   task automatic t_crc;
      wr(PXC_ADDR_IRQ_MASK, 16'h0001);
      pulse_crc(260);
      rd(PXC_ADDR_CTRL4, 16'hADFF, "counter saturated");
      chk_bit(irq, 1'h1, "saturation irq");
      rd(PXC_ADDR_CTRL4, 16'hAD00, "counter cleared");
      wr(PXC_ADDR_IRQ_STAT, 16'h0001);
      pulse_crc(3);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= PXC_ADDR_CTRL4;
      @(posedge core_clk);
      #1;
      chk_word(reg_rdata, 16'hAD03, "counter restarted");
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      chk_word(reg_rdata, 16'hAD00, "back to back read");
      chk_bit(irq, 1'h0, "irq after clear");
      $display("done crc");
   endtask
   task automatic t_carrier;
      logic prx, ptx, e;
      for (int s = 0; s < 8; s++) begin
         wr(PXC_ADDR_CTRL5, 16'h8187 | (16'(s % 4) << 12));
         @(posedge core_clk);
         full_duplex <= s[2];
         run <= 1'h1;
         for (int i = 0; i < 9; i++) begin
            @(posedge core_clk);
            #1;
            e = s[2] ? (prx && !s[0]) : (s[1] ? prx : (prx || ptx));
            if (i > 1) chk_bit(carrier_sense, e, "carrier");
            prx = rx_dv;
            ptx = tx_en;
         end
         run <= 1'h0;
      end
      $display("done carrier");
   endtask
   task automatic t_reserved;
      logic [4:0] a;
      for (int i = 0; i < 4; i++) begin
         a = (i == 3) ? 5'h1D : PXC_ADDR_RSVD_LO + 5'(i);
         wr(a, 16'hFFFF);
         rd(a, 16'h0000, "reserved location");
      end
      $display("done reserved");
   endtask

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      errors++;
      close_out();
   end
   initial begin
      {rst_b, soft_rst, reg_wr, reg_rd, crc_err_pulse, eeprom_detected, full_duplex, run} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      pd_status_in = PXC_PD_SEARCH;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'h1;
      repeat (5) @(posedge core_clk);
      t_defaults();
      t_sticky();
      t_detect();
      t_crc();
      t_carrier();
      t_reserved();
      close_out();
   end
endmodule
`default_nettype wire
